// file: dcc_pkg.sv
package dcc_pkg;
  localparam int          AW             = 4;
  localparam logic [3:0]  OFF_CTL1       = 4'h0;
  localparam logic [3:0]  OFF_CTL2       = 4'h4;
  localparam logic [3:0]  OFF_STAT       = 4'h8;
  localparam logic [3:0]  OFF_IRQ_STAT   = 4'hc;
  localparam logic [3:0]  OFF_IRQ_EN     = 4'h5;
  localparam logic [3:0]  OFF_IRQ_CLR    = 4'h6;
  localparam logic [3:0]  OFF_PRIO       = 4'h7;
  // Control register field positions, then the freeze and idle bits of the status register
  localparam int          B_ON           = 15;
  localparam int          B_OE           = 14;
  localparam int          B_INV          = 13;
  localparam int          B_RES          = 8;
  localparam int          B_EDGE         = 6;
  localparam int          B_PSEL         = 4;
  localparam int          B_NSEL         = 0;
  localparam int          B_FRZ          = 14;
  localparam int          B_IDL          = 13;
  // Writable bits of a control register and its value after reset
  localparam logic [31:0] CTL_WMASK      = 32'h0000_e0d3;
  localparam logic [31:0] CTL_RST        = 32'h0000_00c3;
  localparam logic [31:0] STAT_WMASK     = 32'h0000_6000;
  localparam logic [31:0] PRIO_WMASK     = 32'h001f_1f00;
  localparam logic [31:0] PRIO_RST       = 32'h0000_0000;
  localparam logic [1:0]  NSEL_FIXED     = 2'h3;
  localparam logic [1:0]  NSEL_OTHER     = 2'h2;
  localparam logic [1:0]  NSEL_OWNPOS    = 2'h1;
  localparam logic [1:0]  NSEL_OWNNEG    = 2'h0;
  localparam logic [1:0]  EDGE_BOTH      = 2'h3;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  // Input mux codes handed to the analog core
  localparam logic [1:0]  SRC_OWNPIN     = 2'h0;
  localparam logic [1:0]  SRC_OTHERPIN   = 2'h1;
  localparam logic [1:0]  SRC_ADJREF     = 2'h2;
  localparam logic [1:0]  SRC_FIXREF     = 2'h3;
  localparam logic [2:0]  NSRC_OWNNEG    = 3'h0;
  localparam logic [2:0]  NSRC_OWNPOS    = 3'h1;
  localparam logic [2:0]  NSRC_OTHERPOS  = 3'h2;
  localparam logic [2:0]  NSRC_FIXREF    = 3'h3;
endpackage : dcc_pkg

// file: dcc_channel.sv
`timescale 1ns/10ps
module dcc_channel
  import dcc_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       nrst,       // Async reset, active low
  input  wire logic       ce,         // Clock enable
  input  wire logic       run,        // Comparator enabled and not stopped
  input  wire logic       inv,        // Output invert
  input  wire logic [1:0] edge_sel,   // Interrupt edge select
  input  wire logic       raw_in,     // Raw analog result, asynchronous
  output logic            result_r,   // Polarity-adjusted synced result
  output logic            event_r     // One-cycle interrupt event
);
  logic sync1_r;
  logic sync2_r;
  logic valid_r;
  logic res_nxt;
  logic rise;
  logic fall;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  assign res_nxt = run & (sync2_r ^ inv);
  assign rise    = res_nxt & ~result_r;
  assign fall    = ~res_nxt & result_r;

  // valid_r blocks a spurious edge on the cycle the comparator turns on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      result_r <= 1'b0;
      valid_r  <= 1'b0;
      event_r  <= 1'b0;
    end else if (ce) begin
      result_r <= res_nxt;
      valid_r  <= run;
      event_r  <= run & valid_r &                                // RQ8
        ((edge_sel == EDGE_BOTH & (rise | fall)) |               // RQ5
         (edge_sel == EDGE_FALL & fall) |                        // RQ8
         (edge_sel == EDGE_RISE & rise));                        // RQ8
    end
  end

  a_event_cause: assert property (@(posedge clk) disable iff (!nrst)
    ce && $rose(event_r) |-> valid_r && $past(run)) // RQ8
    else $error("event raised while comparator off");
endmodule : dcc_channel

// file: dcc_top.sv
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
// Operation
// (RQ1) Comparator one takes the adjustable reference on its plus input when the select bit is one, else its own plus pin.
// (RQ2) Comparator one minus select: 11 fixed reference, 10 second plus pin, 01 own plus pin, 00 own minus pin.
// (RQ3) Comparator two takes the adjustable reference on its plus input when the select bit is one, else its own plus pin.
// (RQ4) Comparator two minus select: 11 fixed reference, 10 first plus pin, 01 own plus pin, 00 own minus pin.
// (RQ5) Edge select 11 raises the event on both rising and falling result edges.
// (RQ6) Reserved bits are written as zero by software and read back here as zero.
// (RQ7) A control register resets with edge and minus select bits at one and all else clear.
// (RQ8) Edge select 10 is falling only, 01 rising only, 00 none, seen on the inverted result while enabled.
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic          clk,          // 100 MHz clock
  input  wire logic          nrst,         // Async reset, active low
  input  wire logic          ce,           // Clock enable
  input  wire logic [AW-1:0] addr,         // Register address
  input  wire logic [31:0]   wdata,        // Write data
  input  wire logic          wr,           // Write strobe
  input  wire logic          rd,           // Read strobe
  output logic      [31:0]   rdata_r,      // Read data, cycle after rd
  input  wire logic          cpu_debug,    // CPU in debug mode
  input  wire logic          cpu_idle,     // CPU in idle mode
  input  wire logic          raw1,         // Comparator one analog result
  input  wire logic          raw2,         // Comparator two analog result
  output logic      [1:0]    psrc1_r,      // Plus input source, one
  output logic      [2:0]    nsrc1_r,      // Minus input source, one
  output logic      [1:0]    psrc2_r,      // Plus input source, two
  output logic      [2:0]    nsrc2_r,      // Minus input source, two
  output logic               ana_on1_r,    // Analog core one powered
  output logic               ana_on2_r,    // Analog core two powered
  output logic               pin1_out_r,   // Result pin one value
  output logic               pin1_oe_r,    // Result pin one drive enable
  output logic               pin2_out_r,   // Result pin two value
  output logic               pin2_oe_r,    // Result pin two drive enable
  output logic               irq_r         // Level interrupt
);
  logic [31:0] ctl1_r;
  logic [31:0] ctl2_r;
  logic        frz_r;
  logic        idl_r;
  logic [31:0] prio_r;
  logic [1:0]  ist_r;
  logic [1:0]  ien_r;
  logic        dbg1_r;
  logic        dbg2_r;
  logic        idle1_r;
  logic        idle2_r;
  logic        run1;
  logic        run2;
  logic        res1;
  logic        res2;
  logic        ev1;
  logic        ev2;
  logic        halt;
  logic [31:0] rd_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [31:0] msk);
    merge = (old & ~msk) | (val & msk);
  endfunction : merge

  function automatic logic [2:0] nsel_dec(input logic [1:0] sel);
    case (sel)
      NSEL_FIXED:  nsel_dec = NSRC_FIXREF;
      NSEL_OTHER:  nsel_dec = NSRC_OTHERPOS;
      NSEL_OWNPOS: nsel_dec = NSRC_OWNPOS;
      default:     nsel_dec = NSRC_OWNNEG;
    endcase
  endfunction : nsel_dec

  // Debug and idle come from the CPU's clock tree boundary: synchronise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dbg1_r  <= 1'b0;
      dbg2_r  <= 1'b0;
      idle1_r <= 1'b0;
      idle2_r <= 1'b0;
    end else if (ce) begin
      dbg1_r  <= cpu_debug;
      dbg2_r  <= dbg1_r;
      idle1_r <= cpu_idle;
      idle2_r <= idle1_r;
    end
  end

  // Freeze in debug and idle stop both drop run: cores power off, results go low, no events
  assign halt = (frz_r & dbg2_r) | (idl_r & idle2_r);
  assign run1 = ctl1_r[B_ON] & ~halt;
  assign run2 = ctl2_r[B_ON] & ~halt;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl1_r <= CTL_RST; // RQ7
      ctl2_r <= CTL_RST; // RQ7
      prio_r <= PRIO_RST;
      frz_r  <= 1'b0;
      idl_r  <= 1'b0;
    end else if (ce && wr) begin
      case (addr)
        OFF_CTL1: ctl1_r <= merge(ctl1_r, wdata, CTL_WMASK); // RQ6
        OFF_CTL2: ctl2_r <= merge(ctl2_r, wdata, CTL_WMASK); // RQ6
        OFF_PRIO: prio_r <= merge(prio_r, wdata, PRIO_WMASK);
        OFF_STAT: begin
          // Freeze control is only writable while the CPU is in debug
          if (dbg2_r) begin
            frz_r <= wdata[B_FRZ];
          end
          idl_r <= wdata[B_IDL];
        end
        default: ;
      endcase
    end
  end

  // Interrupt status: set wins over a clear in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ist_r <= 2'h0;
      ien_r <= 2'h0;
    end else if (ce) begin
      if (wr && addr == OFF_IRQ_EN) begin
        ien_r <= wdata[1:0];
      end
      ist_r <= (ist_r & ~((wr && addr == OFF_IRQ_CLR) ? wdata[1:0] : 2'h0))
               | {ev2, ev1};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(ist_r & ien_r);
    end
  end

  dcc_channel u_ch1 (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .run      (run1),
    .inv      (ctl1_r[B_INV]),
    .edge_sel (ctl1_r[B_EDGE +: 2]),
    .raw_in   (raw1),
    .result_r (res1),
    .event_r  (ev1)
  );

  dcc_channel u_ch2 (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .run      (run2),
    .inv      (ctl2_r[B_INV]),
    .edge_sel (ctl2_r[B_EDGE +: 2]),
    .raw_in   (raw2),
    .result_r (res2),
    .event_r  (ev2)
  );

  // Input routing toward the analog cores
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      psrc1_r <= SRC_OWNPIN;
      psrc2_r <= SRC_OWNPIN;
      nsrc1_r <= NSRC_FIXREF;
      nsrc2_r <= NSRC_FIXREF;
    end else if (ce) begin
      psrc1_r <= ctl1_r[B_PSEL] ? SRC_ADJREF : SRC_OWNPIN; // RQ1
      psrc2_r <= ctl2_r[B_PSEL] ? SRC_ADJREF : SRC_OWNPIN; // RQ3
      nsrc1_r <= nsel_dec(ctl1_r[B_NSEL +: 2]); // RQ2
      nsrc2_r <= nsel_dec(ctl2_r[B_NSEL +: 2]); // RQ4
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ana_on1_r  <= 1'b0;
      ana_on2_r  <= 1'b0;
      pin1_out_r <= 1'b0;
      pin1_oe_r  <= 1'b0;
      pin2_out_r <= 1'b0;
      pin2_oe_r  <= 1'b0;
    end else if (ce) begin
      ana_on1_r  <= run1;
      ana_on2_r  <= run2;
      pin1_out_r <= res1;
      pin1_oe_r  <= ctl1_r[B_OE];
      pin2_out_r <= res2;
      pin2_oe_r  <= ctl2_r[B_OE];
    end
  end

  // Reserved bits read zero; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0;
    case (addr)
      OFF_CTL1: rd_nxt = (ctl1_r & CTL_WMASK) | (32'(res1) << B_RES); // RQ6
      OFF_CTL2: rd_nxt = (ctl2_r & CTL_WMASK) | (32'(res2) << B_RES); // RQ6
      OFF_STAT: rd_nxt = (32'(frz_r & dbg2_r) << B_FRZ) |
                         (32'(idl_r) << B_IDL) | {30'h0, res2, res1};
      OFF_IRQ_STAT: rd_nxt = {30'h0, ist_r};
      OFF_IRQ_EN:   rd_nxt = {30'h0, ien_r};
      OFF_PRIO:     rd_nxt = prio_r;
      default:      rd_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0;
    end else if (ce) begin
      rdata_r <= rd ? rd_nxt : 32'h0;
    end
  end

  a_route_pos1: assert property (@(posedge clk) disable iff (!nrst)
    ce |=> psrc1_r == ($past(ctl1_r[B_PSEL]) ? SRC_ADJREF : SRC_OWNPIN)) // RQ1
    else $error("plus source one wrong");
  a_route_neg1: assert property (@(posedge clk) disable iff (!nrst)
    ce && ctl1_r[1:0] == NSEL_OTHER |=> nsrc1_r == NSRC_OTHERPOS) // RQ2
    else $error("minus source one wrong");
  a_route_pos2: assert property (@(posedge clk) disable iff (!nrst)
    ce && ctl2_r[B_PSEL] |=> psrc2_r == SRC_ADJREF) // RQ3
    else $error("plus source two wrong");
  a_route_neg2: assert property (@(posedge clk) disable iff (!nrst)
    ce && ctl2_r[1:0] == NSEL_FIXED |=> nsrc2_r == NSRC_FIXREF) // RQ4
    else $error("minus source two wrong");
  a_both_edges: assert property (@(posedge clk) disable iff (!nrst)
    ce && run1 && $past(run1) && $past(run1, 2) &&
    ctl1_r[7:6] == EDGE_BOTH && $past(ctl1_r[7:6]) == EDGE_BOTH &&
    res1 != $past(res1) && $past(ce) |-> ev1) // RQ5
    else $error("edge missed in both mode");
  a_resv_zero: assert property (@(posedge clk) disable iff (!nrst)
    ce && rd && addr == OFF_CTL1 |=> rdata_r[31:16] == 16'h0) // RQ6
    else $error("reserved bits read nonzero");
  a_reset_ctl: assert property (@(posedge clk)
    !nrst |=> ctl1_r == CTL_RST || !$past(nrst) == 1'b0) // RQ7
    else $error("control reset value wrong");
  a_no_edge0: assert property (@(posedge clk) disable iff (!nrst)
    ce && ctl2_r[7:6] == 2'h0 && $past(ctl2_r[7:6]) == 2'h0 |=> !ev2) // RQ8
    else $error("event with edges off");
  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    ce && |(ist_r & ien_r) |=> irq_r)
    else $error("interrupt not raised");

  c_ev1:   cover property (@(posedge clk) disable iff (!nrst) ev1);
  c_ev2:   cover property (@(posedge clk) disable iff (!nrst) ev2);
  c_irq:   cover property (@(posedge clk) disable iff (!nrst) $rose(irq_r));
  c_halt:  cover property (@(posedge clk) disable iff (!nrst) halt);
endmodule : dcc_top

// file: dcc_top_bench.sv
`timescale 1ns/10ps
`define CHK(a, e) begin \
  checks_done++; \
  if ((a) !== (e)) begin \
    mismatches++; \
    $display("FAIL t=%0t got %h exp %h", $time, a, e); \
  end \
end

module dcc_top_bench;
  import dcc_pkg::*;
  logic            clk, nrst, ce, wr, rd, cpu_debug, cpu_idle, raw1, raw2;
  logic [AW-1:0]   addr;
  logic [31:0]     wdata, rdata_r, rv;
  logic [1:0]      psrc1_r, psrc2_r;
  logic [2:0]      nsrc1_r, nsrc2_r;
  logic            ana_on1_r, ana_on2_r, pin1_out_r, pin1_oe_r;
  logic            pin2_out_r, pin2_oe_r, irq_r;
  int              mismatches, checks_done;

  dcc_top dcc_top_i (.clk(clk), .nrst(nrst), .ce(ce), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r),
    .cpu_debug(cpu_debug), .cpu_idle(cpu_idle), .raw1(raw1), .raw2(raw2),
    .psrc1_r(psrc1_r), .nsrc1_r(nsrc1_r), .psrc2_r(psrc2_r),
    .nsrc2_r(nsrc2_r), .ana_on1_r(ana_on1_r), .ana_on2_r(ana_on2_r),
    .pin1_out_r(pin1_out_r), .pin1_oe_r(pin1_oe_r),
    .pin2_out_r(pin2_out_r), .pin2_oe_r(pin2_oe_r), .irq_r(irq_r));

  always #5 clk = ~clk;

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata_r;
  endtask : rd_reg

  task set_raw(input int ch, input logic v);
    @(posedge clk);
    if (ch == 0) raw1 <= v;
    else raw2 <= v;
  endtask : set_raw

  function automatic logic [2:0] nexp(input logic [1:0] n);
    case (n)
      2'h3:    return 3'h3;
      2'h2:    return 3'h2;
      2'h1:    return 3'h1;
      default: return 3'h0;
    endcase
  endfunction : nexp

  task reset_test;
    `CHK(psrc1_r, 2'h0)
    `CHK(nsrc1_r, 3'h3)
    `CHK(nsrc2_r, 3'h3)
    `CHK(irq_r, 1'b0)
    rd_reg(OFF_CTL1, rv);
    `CHK(rv, 32'h0000_00c3)
    rd_reg(OFF_CTL2, rv);
    `CHK(rv, 32'h0000_00c3)
    wr_reg(4'h1, 32'h0000_ffff);
    rd_reg(4'h1, rv);
    `CHK(rv, 32'h0000_0000)
    rd_reg(OFF_CTL1, rv);
    `CHK(rv, 32'h0000_00c3)
  endtask : reset_test

  // Every plus and minus select code on both channels
  task route_test;
    logic [31:0] v;
    for (int ch = 0; ch < 2; ch++) begin
      for (int p = 0; p < 2; p++) begin
        for (int n = 0; n < 4; n++) begin
          v = (32'(p) << B_PSEL) | 32'(n);
          wr_reg(ch ? OFF_CTL2 : OFF_CTL1, v);
          rd_reg(ch ? OFF_CTL2 : OFF_CTL1, rv);
          `CHK(rv, v)
          if (ch == 0) begin
            `CHK(psrc1_r, (p ? 2'h2 : 2'h0))
            `CHK(nsrc1_r, nexp(2'(n)))
          end else begin
            `CHK(psrc2_r, (p ? 2'h2 : 2'h0))
            `CHK(nsrc2_r, nexp(2'(n)))
          end
        end
      end
    end
  endtask : route_test

  task edge_case(input int ch, input logic [1:0] es, input logic iv);
    logic rise_exp, fall_exp;
    rise_exp = iv ? es[1] : es[0];
    fall_exp = iv ? es[0] : es[1];
    set_raw(ch, 1'b0);
    wr_reg(ch ? OFF_CTL2 : OFF_CTL1,
           32'h0000_c000 | (32'(iv) << B_INV) | (32'(es) << B_EDGE));
    cyc(8);
    wr_reg(OFF_IRQ_CLR, 32'h3);
    cyc(3);
    `CHK((ch ? pin2_oe_r : pin1_oe_r), 1'b1)
    set_raw(ch, 1'b1);
    cyc(8);
    rd_reg(OFF_IRQ_STAT, rv);
    `CHK(rv[ch], rise_exp)
    `CHK(irq_r, rise_exp)
    `CHK((ch ? pin2_out_r : pin1_out_r), ~iv)
    rd_reg(OFF_STAT, rv);
    `CHK(rv[ch], ~iv)
    wr_reg(OFF_IRQ_CLR, 32'h3);
    cyc(3);
    `CHK(irq_r, 1'b0)
    set_raw(ch, 1'b0);
    cyc(8);
    rd_reg(OFF_IRQ_STAT, rv);
    `CHK(rv[ch], fall_exp)
    wr_reg(OFF_IRQ_CLR, 32'h3);
  endtask : edge_case

  // A masked event stays pending until the enable is set
  task mask_test;
    edge_case(1, EDGE_BOTH, 1'b0);
    wr_reg(OFF_IRQ_EN, 32'h0);
    set_raw(1, 1'b1);
    cyc(8);
    rd_reg(OFF_IRQ_STAT, rv);
    `CHK(rv[1], 1'b1)
    `CHK(irq_r, 1'b0)
    wr_reg(OFF_IRQ_EN, 32'h3);
    cyc(3);
    `CHK(irq_r, 1'b1)
    wr_reg(OFF_IRQ_CLR, 32'h3);
    cyc(3);
    `CHK(irq_r, 1'b0)
  endtask : mask_test

  task idle_test;
    wr_reg(OFF_STAT, 32'h0000_2000);
    cpu_idle <= 1'b1;
    cyc(6);
    `CHK(ana_on2_r, 1'b0)
    rd_reg(OFF_STAT, rv);
    `CHK(rv[1], 1'b0)
    cpu_idle <= 1'b0;
    cyc(6);
    `CHK(ana_on2_r, 1'b1)
  endtask : idle_test

  // Freeze in debug halts the cores; a low clock enable drops a write
  task freeze_ce_test;
    cpu_debug <= 1'b1;
    cyc(3);
    wr_reg(OFF_STAT, 32'h0000_4000);
    cyc(4);
    `CHK(ana_on2_r, 1'b0)
    rd_reg(OFF_STAT, rv);
    `CHK(rv[14], 1'b1)
    cpu_debug <= 1'b0;
    cyc(6);
    `CHK(ana_on2_r, 1'b1)
    ce <= 1'b0;
    wr_reg(OFF_CTL1, 32'h0);
    ce <= 1'b1;
    rd_reg(OFF_CTL1, rv);
    `CHK(rv, 32'h0000_c0c0)
  endtask : freeze_ce_test

  task summarize;
    if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  initial begin
    {clk, nrst, wr, rd, cpu_debug, cpu_idle, raw1, raw2} = '0;
    ce    = 1'b1;
    addr  = '0;
    wdata = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    cyc(1);
    reset_test();
    route_test();
    wr_reg(OFF_IRQ_EN, 32'h3);
    for (int e = 0; e < 4; e++) edge_case(0, 2'(e), 1'b0);
    edge_case(1, EDGE_RISE, 1'b1);
    edge_case(1, EDGE_FALL, 1'b1);
    mask_test();
    idle_test();
    freeze_ce_test();
    summarize();
  end
endmodule : dcc_top_bench
